// >>> rtl/scp_consts.vh
// constants for the system clock source and prescaler block
`ifndef SCP_CONSTS_VH
`define SCP_CONSTS_VH

// register byte offsets
`define SCP_ADDR_SYS_CFG 4'h0
`define SCP_ADDR_LOOP_CFG 4'h4
`define SCP_ADDR_MEM_CTRL 4'h8
`define SCP_ADDR_STATUS 4'hc

// source select codes
`define SCP_SEL_WAKEUP 2'h0
`define SCP_SEL_PRESCALE 2'h2
`define SCP_SEL_DIRECT 2'h3

// field positions
`define SCP_SEL_LSB 0
`define SCP_BYPASS_BIT 0
`define SCP_OSC_SRC_BIT 1
`define SCP_DIV_LSB 16
`define SCP_WAIT_LSB 0

// reset values
`define SCP_SEL_RESET 2'h0
`define SCP_BYPASS_RESET 1'h1
`define SCP_OSC_SRC_RESET 1'h0
`define SCP_DIV_RESET 10'h000
`define SCP_WAIT_RESET 4'h4

// widths
`define SCP_DIV_W 10
`define SCP_WAIT_W 4

// axi responses
`define SCP_RESP_OKAY 2'h0
`define SCP_RESP_SLVERR 2'h2

// one-hot clock paths
`define SCP_PATH_WAKEUP 4'h1
`define SCP_PATH_PLL 4'h2
`define SCP_PATH_PRESCALE 4'h4
`define SCP_PATH_DIRECT 4'h8

`endif

// >>> rtl/scp_prescaler.v
// output prescaler: divides a sampled oscillator level by divide field plus one
`timescale 1ns/1ps
`default_nettype none
module scp_prescaler #(
  parameter DIV_W = 10
) (
  // clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // oscillator level, already synchronised
  input wire osc_level,
  // divide field (factor minus one)
  input wire [DIV_W-1:0] div_field,
  // divided output
  output reg div_out_reg
);

  reg osc_prev_reg;
  reg [DIV_W-1:0] cnt_reg;
  reg [DIV_W-1:0] cnt_next;
  wire [DIV_W:0] factor;
  wire [DIV_W:0] half;
  wire osc_rise;

  assign osc_rise = osc_level & ~osc_prev_reg;
  assign factor = {1'b0, div_field} + {{DIV_W{1'b0}}, 1'b1};
  assign half = factor >> 1;

  always @* begin
    if (cnt_reg >= div_field) begin
      cnt_next = {DIV_W{1'b0}};
    end else begin
      cnt_next = cnt_reg + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      osc_prev_reg <= 1'b0;
      cnt_reg <= {DIV_W{1'b0}};
      div_out_reg <= 1'b0;
    end else begin
      osc_prev_reg <= osc_level;
      if (div_field == {DIV_W{1'b0}}) begin
        // factor one: phases follow the oscillator duty cycle [R4]
        cnt_reg <= {DIV_W{1'b0}};
        div_out_reg <= osc_level;
      end else if (osc_rise) begin
        // one output period per factor oscillator periods, up to 1024 [R3] [R5]
        cnt_reg <= cnt_next;
        div_out_reg <= ({1'b0, cnt_next} < half);
      end
    end
  end

endmodule
`default_nettype wire

// >>> rtl/scp_clock_ctrl.v
// system clock source selection, prescaler control and flash wait-state timing
// Behaviour
// R1: select 11 drives system clock straight from external clock pin.
// R2: select 10 with bypass 1 uses crystal or internal source via prescaler.
// R3: prescale factor is divide field plus one; output is oscillator over factor.
// R4: factor one passes oscillator with its own duty cycle.
// R5: divide factor reaches 1024 at most.
// R6: software sets wait states 1/2/3/4 for up to 8/13/17 MHz and above.
// R7: wait states apply to non-sequential flash accesses only; sequential use prefetch.
// R8: select 10 with bypass 0 enables the loop and takes its clock.
// R9: select 00 takes the low-frequency wakeup clock.
// R10: select codes decode combinationally to exactly one active clock path.
`timescale 1ns/1ps
`default_nettype none
`include "scp_consts.vh"
module scp_clock_ctrl #(
  parameter DIV_W = `SCP_DIV_W,
  parameter WAIT_W = `SCP_WAIT_W
) (
  // clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // axi4-lite write address
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // clock source pins
  input wire ext_clock_input_pin,
  input wire crystal_input_pin,
  input wire int_osc_in,
  input wire loop_clk_in,
  input wire wakeup_clk_in,
  // clock outputs
  output reg sys_clock_out_reg,
  output reg loop_enable_reg,
  output reg [3:0] active_path_reg,
  // flash access
  input wire flash_req,
  input wire flash_seq,
  output reg flash_ack_reg
);

  localparam ST_IDLE = 2'b01;
  localparam ST_WAIT = 2'b10;

  // configuration fields
  reg [1:0] sys_clock_source_select;
  reg oscillator_bypass_select;
  reg osc_source_select;
  reg [DIV_W-1:0] out_prescale_divide_field;
  reg [WAIT_W-1:0] flash_wait_cycles;

  // pin synchronisers, two flops each
  reg [4:0] pin_meta_reg;
  reg [4:0] pin_sync_reg;
  wire ext_lvl = pin_sync_reg[0];
  wire xtal_lvl = pin_sync_reg[1];
  wire int_lvl = pin_sync_reg[2];
  wire loop_lvl = pin_sync_reg[3];
  wire wu_lvl = pin_sync_reg[4];

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      pin_meta_reg <= 5'h00;
      pin_sync_reg <= 5'h00;
    end else begin
      pin_meta_reg <= {wakeup_clk_in, loop_clk_in, int_osc_in, crystal_input_pin, ext_clock_input_pin};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // one-hot path decode; code 01 is not a clock source and keeps wakeup running
  function [3:0] path_decode;
    input [1:0] sel;
    input bypass;
    begin
      case (sel)
        `SCP_SEL_DIRECT: path_decode = `SCP_PATH_DIRECT; // [R1] [R10]
        `SCP_SEL_PRESCALE: path_decode = bypass ? `SCP_PATH_PRESCALE : `SCP_PATH_PLL; // [R2] [R8] [R10]
        default: path_decode = `SCP_PATH_WAKEUP; // [R9] [R10]
      endcase
    end
  endfunction

  wire [3:0] path = path_decode(sys_clock_source_select, oscillator_bypass_select);
  wire osc_lvl = osc_source_select ? int_lvl : xtal_lvl; // [R2]
  wire presc_out;

  scp_prescaler #(
    .DIV_W(DIV_W)
  ) u_presc (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .osc_level(osc_lvl),
    .div_field(out_prescale_divide_field),
    .div_out_reg(presc_out)
  );

  reg clk_sel_next;
  always @* begin
    case (path)
      `SCP_PATH_DIRECT: clk_sel_next = ext_lvl; // [R1]
      `SCP_PATH_PRESCALE: clk_sel_next = presc_out; // [R3]
      `SCP_PATH_PLL: clk_sel_next = loop_lvl; // [R8]
      default: clk_sel_next = wu_lvl; // [R9]
    endcase
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      sys_clock_out_reg <= 1'b0;
      loop_enable_reg <= 1'b0;
      active_path_reg <= `SCP_PATH_WAKEUP;
    end else begin
      sys_clock_out_reg <= clk_sel_next;
      loop_enable_reg <= (path == `SCP_PATH_PLL); // [R8]
      active_path_reg <= path;
    end
  end

  // axi4-lite write side: address and data latched in either order
  reg aw_held_reg;
  reg w_held_reg;
  reg [3:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire aw_have = aw_held_reg | aw_take;
  wire w_have = w_held_reg | w_take;
  wire [3:0] wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
  wire [31:0] wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
  wire [3:0] wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb;
  wire wr_fire = aw_have & w_have & ~s_axi_bvalid;

  assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_reg & ~s_axi_bvalid;

  function addr_mapped;
    input [3:0] a;
    begin
      addr_mapped = (a == `SCP_ADDR_SYS_CFG) | (a == `SCP_ADDR_LOOP_CFG) |
                    (a == `SCP_ADDR_MEM_CTRL) | (a == `SCP_ADDR_STATUS);
    end
  endfunction

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 4'h0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SCP_RESP_OKAY;
      sys_clock_source_select <= `SCP_SEL_RESET;
      oscillator_bypass_select <= `SCP_BYPASS_RESET;
      osc_source_select <= `SCP_OSC_SRC_RESET;
      out_prescale_divide_field <= `SCP_DIV_RESET;
      flash_wait_cycles <= `SCP_WAIT_RESET;
    end else begin
      if (aw_take) begin
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_mapped(wr_addr) ? `SCP_RESP_OKAY : `SCP_RESP_SLVERR;
        if (wr_addr == `SCP_ADDR_SYS_CFG && wr_strb[0]) begin
          sys_clock_source_select <= wr_data[`SCP_SEL_LSB+1:`SCP_SEL_LSB];
        end
        if (wr_addr == `SCP_ADDR_LOOP_CFG) begin
          if (wr_strb[0]) begin
            oscillator_bypass_select <= wr_data[`SCP_BYPASS_BIT];
            osc_source_select <= wr_data[`SCP_OSC_SRC_BIT];
          end
          // divide field straddles two byte lanes
          if (wr_strb[2]) begin
            out_prescale_divide_field[7:0] <= wr_data[`SCP_DIV_LSB+7:`SCP_DIV_LSB];
          end
          if (wr_strb[3]) begin
            out_prescale_divide_field[DIV_W-1:8] <= wr_data[`SCP_DIV_LSB+DIV_W-1:`SCP_DIV_LSB+8];
          end
        end
        // software owns the frequency-to-wait-state match [R6]
        if (wr_addr == `SCP_ADDR_MEM_CTRL && wr_strb[0]) begin
          flash_wait_cycles <= wr_data[`SCP_WAIT_LSB+WAIT_W-1:`SCP_WAIT_LSB];
        end
      end else begin
        if (aw_take) begin
          aw_held_reg <= 1'b1;
        end
        if (w_take) begin
          w_held_reg <= 1'b1;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // axi4-lite read side
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SCP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= addr_mapped(s_axi_araddr) ? `SCP_RESP_OKAY : `SCP_RESP_SLVERR;
      case (s_axi_araddr)
        `SCP_ADDR_SYS_CFG: s_axi_rdata <= {30'h00000000, sys_clock_source_select};
        `SCP_ADDR_LOOP_CFG: s_axi_rdata <= {6'h00, out_prescale_divide_field, 14'h0000,
                                            osc_source_select, oscillator_bypass_select};
        `SCP_ADDR_MEM_CTRL: s_axi_rdata <= {28'h0000000, flash_wait_cycles};
        `SCP_ADDR_STATUS: s_axi_rdata <= {26'h0000000, loop_enable_reg, sys_clock_out_reg, active_path_reg};
        default: s_axi_rdata <= 32'h00000000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // flash access timing: a prefetch hit answers next cycle, a jump waits
  reg [1:0] fl_state_reg;
  reg [WAIT_W-1:0] fl_cnt_reg;

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      fl_state_reg <= ST_IDLE;
      fl_cnt_reg <= {WAIT_W{1'b0}};
      flash_ack_reg <= 1'b0;
    end else begin
      flash_ack_reg <= 1'b0;
      case (fl_state_reg)
        ST_IDLE: begin
          if (flash_req) begin
            if (flash_seq || flash_wait_cycles == {WAIT_W{1'b0}}) begin
              flash_ack_reg <= 1'b1; // [R7]
            end else begin
              fl_cnt_reg <= flash_wait_cycles; // [R7]
              fl_state_reg <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          if (fl_cnt_reg == {{(WAIT_W-1){1'b0}}, 1'b1}) begin
            flash_ack_reg <= 1'b1;
            fl_state_reg <= ST_IDLE;
          end
          fl_cnt_reg <= fl_cnt_reg - {{(WAIT_W-1){1'b0}}, 1'b1};
        end
        default: fl_state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> rtl/HANDOVER_placeholder_unused.v
// empty unit: holds no logic
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> tb/scp_osc_model.sv
// free-running oscillator and clock sources at the block's pins
`timescale 1ns/1ps
`default_nettype none
module scp_osc_model (
  // clock
  input wire logic sys_clk,
  // source levels
  output wire logic ext_clock_input_pin,
  output wire logic crystal_input_pin,
  output wire logic int_osc_in,
  output wire logic loop_clk_in,
  output wire logic wakeup_clk_in
);
  // distinct periods, and uneven duty cycles on all but the loop and wakeup clocks, so a wrong path or a lost duty cycle shows up
  int n = 0;
  always @(posedge sys_clk) begin
    n <= n + 1;
  end
  assign ext_clock_input_pin = (n % 6) < 2;
  assign crystal_input_pin = (n % 8) < 3;
  assign int_osc_in = (n % 10) < 4;
  assign loop_clk_in = (n % 4) < 2;
  assign wakeup_clk_in = (n % 14) < 7;
endmodule
`default_nettype wire

// >>> tb/scp_ctrl_checker.sv
// port assertions for the clock control block
`timescale 1ns/1ps
`default_nettype none
module scp_ctrl_checker (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // bus signals, two clock source pins and clock outputs
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_clock_input_pin,
  input wire logic wakeup_clk_in,
  input wire logic sys_clock_out_reg,
  input wire logic loop_enable_reg,
  input wire logic [3:0] active_path_reg,
  input wire logic flash_ack_reg
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  write_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  one_path_a: assert property ($onehot(active_path_reg))
    else $error("clock path not one-hot");
  loop_path_a: assert property (loop_enable_reg == (active_path_reg == 4'h2))
    else $error("loop enable and path disagree");
  // the synchronisers restart from zero, so the pin history only counts three clean cycles after reset
  direct_follow_a: assert property (active_path_reg == 4'h8 && $past(active_path_reg, 3) == 4'h8 &&
    !$past(sys_rst, 1) && !$past(sys_rst, 2) && !$past(sys_rst, 3) |->
    sys_clock_out_reg == $past(ext_clock_input_pin, 3)) else $error("direct clock not followed");
  wakeup_follow_a: assert property (active_path_reg == 4'h1 && $past(active_path_reg, 3) == 4'h1 &&
    !$past(sys_rst, 1) && !$past(sys_rst, 2) && !$past(sys_rst, 3) |->
    sys_clock_out_reg == $past(wakeup_clk_in, 3)) else $error("wakeup clock not followed");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (active_path_reg == 4'h8);
  cover property (flash_ack_reg);
endmodule
bind scp_clock_ctrl scp_ctrl_checker chk (.*);
`default_nettype wire

// >>> tb/sys_clock_source_prescaler_test.sv
// self-checking bench for the system clock control block
`timescale 1ns/1ps
`default_nettype none
module sys_clock_source_prescaler_test;
  logic sys_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0, flash_req = 1'h0, flash_seq = 1'h0;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic sys_clock_out_reg, loop_enable_reg, flash_ack_reg;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [3:0] active_path_reg;
  wire logic ext_clock_input_pin, crystal_input_pin, int_osc_in, loop_clk_in, wakeup_clk_in;
  int n_tests = 0;
  int n_mismatch = 0;
  logic [1:0] rd_resp = 2'h0;
  scp_clock_ctrl dut (.*);
  scp_osc_model osc (.*);
  always #5 sys_clk = ~sys_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w;
    aw = 1'h0;
    w = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (!(aw && w)) begin
      @(posedge sys_clk);
      if (!aw && s_axi_awready === 1'h1) begin
        aw = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (!w && s_axi_wready === 1'h1) begin
        w = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    s_axi_bready <= 1'h1;
    do @(posedge sys_clk); while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    s_axi_rready <= 1'h1;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    rd_resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  // counts cycles high and cycles per period from one rising edge to the next
  task automatic meas(output int per, output int hi);
    hi = 0;
    while (sys_clock_out_reg !== 1'h0) @(posedge sys_clk);
    while (sys_clock_out_reg !== 1'h1) @(posedge sys_clk);
    while (sys_clock_out_reg === 1'h1) begin
      @(posedge sys_clk);
      hi++;
    end
    per = hi;
    while (sys_clock_out_reg !== 1'h1) begin
      @(posedge sys_clk);
      per++;
    end
  endtask
  // first period after a switch may be cut short, so it is thrown away
  task automatic path_chk(input logic [31:0] lcfg, sel, input int per, hi, input logic [31:0] st);
    int p, h;
    logic [1:0] r;
    logic [31:0] d;
    wr(4'h4, lcfg, r);
    wr(4'h0, sel, r);
    meas(p, h);
    meas(p, h);
    chk(32'(p), 32'(per));
    chk(32'(h), 32'(hi));
    rd(4'hc, d);
    chk(d & 32'h2f, st);
  endtask
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    rd(4'h0, d);
    chk(d, 32'h0);
    rd(4'h4, d);
    chk(d, 32'h1);
    rd(4'h8, d);
    chk(d, 32'h4);
    chk(32'(rd_resp), 32'h0);
    wr(4'h1, 32'h3, r);
    chk(32'(r), 32'h2);
    rd(4'h0, d);
    chk(d, 32'h0);
    rd(4'h2, d);
    chk(d, 32'h0);
    chk(32'(rd_resp), 32'h2);
    wr(4'hc, 32'hff, r);
    chk(32'(r), 32'h0);
    rd(4'hc, d);
    chk(d & 32'h2f, 32'h1);
    $display("test regs done");
  endtask
  task automatic t_paths;
    path_chk(32'h1, 32'h3, 6, 2, 32'h08);
    path_chk(32'h1, 32'h2, 8, 3, 32'h04);
    path_chk(32'h3, 32'h2, 10, 4, 32'h04);
    path_chk(32'h0002_0001, 32'h2, 24, 8, 32'h04);
    path_chk(32'h0, 32'h2, 4, 2, 32'h22);
    path_chk(32'h0, 32'h0, 14, 7, 32'h01);
    path_chk(32'h0, 32'h1, 14, 7, 32'h01);
    $display("test paths done");
  endtask
  task automatic t_maxdiv;
    path_chk(32'h03ff_0001, 32'h2, 8192, 4096, 32'h04);
    $display("test maxdiv done");
  endtask
  task automatic fl(input logic s, input int exp);
    int n;
    flash_req <= 1'h1;
    flash_seq <= s;
    @(posedge sys_clk);
    flash_req <= 1'h0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (flash_ack_reg !== 1'h1 && n < 50);
    chk(32'(n), 32'(exp));
  endtask
  task automatic t_flash;
    logic [1:0] r;
    wr(4'h8, 32'h2, r);
    fl(1'h0, 3);
    fl(1'h1, 1);
    wr(4'h8, 32'h4, r);
    fl(1'h0, 5);
    fl(1'h1, 1);
    $display("test flash done");
  endtask
  task automatic report_and_stop;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'h0;
    t_regs;
    t_paths;
    t_flash;
    t_maxdiv;
    report_and_stop;
  end
  initial begin
    #600000;
    n_mismatch++;
    report_and_stop;
  end
endmodule
`default_nettype wire
